// file: logic/azt_zero_g_trim.sv
/*
 * Zero-g trim block: three trim registers on the serial register port, the
 * per-axis correction of each acquired sample and the six output data bytes.
 * Assumes the register port delivers one access per cycle, synchronous to
 * clk_sys, and that the acquisition side pulses sample_valid with a full set.
 */
// How it works
// - Each axis keeps an 8-bit trim word that is read as a signed two's complement number.
// - One trim step is worth 2 mg of acceleration on its axis.
// - The trim reaches from -256 mg to +254 mg, the whole signed 8-bit code space.
// - Each trim is added to its axis sample before the sum lands in output bytes 0x01 to 0x06.
// - Trim writes take effect only in standby; writes while active are dropped.
`timescale 1ns/100ps
module azt_zero_g_trim
	import azt_pkg::*;
#(
	parameter int SAMPLE_W = AZT_SAMPLE_W
) (
	input wire logic clk_sys,
	input wire logic rst,
	input wire azt_reg_req_t reg_req,
	output logic [7:0] reg_rdata,
	output logic reg_rvalid,
	input wire logic active_mode,
	input wire logic [1:0] fs_range,
	input wire logic sample_valid,
	input wire azt_vec_t sample_raw,
	output azt_vec_t sample_out,
	output logic sample_out_valid
);

	////////////////////////////////////////////////////////////////////////////////
	// Helper functions and elaboration checks.

	// A range code outside the table is served as 8 g by the adders.
	function automatic logic fs_range_ok(input logic [1:0] code);
		fs_range_ok = (code == AZT_FS_2G) || (code == AZT_FS_4G) || (code == AZT_FS_8G);
	endfunction

	// Left-justify a sample into its MSB/LSB byte pair, low pad bits zero.
	function automatic logic [15:0] out_word(input logic [SAMPLE_W-1:0] s);
		out_word = {s, {AZT_PAD_W{1'b0}}};
	endfunction

	// Pick one byte of a left-justified output word; the MSB byte sits at the lower address.
	function automatic logic [7:0] out_byte(input logic [15:0] w, input logic low_half);
		out_byte = low_half ? w[7:0] : w[15:8];
	endfunction

	// Address match of one register; shared by the three trim strobes.
	function automatic logic trim_hit(input logic [7:0] addr, input logic [7:0] target);
		trim_hit = (addr == target);
	endfunction

	// The output bytes and the carrier struct are laid out for one sample width only.
	if (SAMPLE_W != AZT_SAMPLE_W) begin : g_bad_width
		$error("azt_zero_g_trim: sample width must match the carrier struct");
	end

	// The pad bits must fill the sample up to a whole byte pair, or the read-back bytes shift.
	if (SAMPLE_W + AZT_PAD_W != 16) begin : g_bad_pad
		$error("azt_zero_g_trim: sample and pad bits must fill two bytes");
	end

	// The 8 g code must be a member of the table that the adders decode.
	if (fs_range_ok(AZT_FS_8G) == 1'b0) begin : g_bad_range
		$error("azt_zero_g_trim: range code table inconsistent");
	end

	// Two ranges sharing a code would make the scaling ambiguous.
	if (AZT_FS_2G == AZT_FS_4G || AZT_FS_4G == AZT_FS_8G || AZT_FS_2G == AZT_FS_8G) begin : g_dup_range
		$error("azt_zero_g_trim: range codes must be distinct");
	end

	logic signed [AZT_TRIM_W-1:0] trim_x_r;
	logic signed [AZT_TRIM_W-1:0] trim_y_r;
	logic signed [AZT_TRIM_W-1:0] trim_z_r;
	azt_vec_t sum_nxt;
	azt_vec_t sample_out_r;
	logic sample_out_valid_r;
	logic [7:0] reg_rdata_r;
	logic reg_rvalid_r;
	logic trim_wr_ok;
	logic trim_x_we;
	logic trim_y_we;
	logic trim_z_we;
	logic [7:0] reg_rdata_nxt;
	logic [15:0] wx;
	logic [15:0] wy;
	logic [15:0] wz;

	////////////////////////////////////////////////////////////////////////////////
	// Trim registers.

	// Standby gate: a write in active mode is dropped silently, the old trim stays in use.
	assign trim_wr_ok = reg_req.wr && !active_mode;

	// One strobe per trim register, each already gated by the standby check.
	assign trim_x_we = trim_wr_ok && trim_hit(reg_req.addr, AZT_ADDR_TRIM_X);
	assign trim_y_we = trim_wr_ok && trim_hit(reg_req.addr, AZT_ADDR_TRIM_Y);
	assign trim_z_we = trim_wr_ok && trim_hit(reg_req.addr, AZT_ADDR_TRIM_Z);

	// X trim; all 256 codes are stored as written, so no clipping narrows the -256..+254 mg span.
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			trim_x_r <= AZT_TRIM_RESET;
		end else if (trim_x_we) begin
			trim_x_r <= reg_req.wdata;
		end
	end

	// Y trim, stored the same way.
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			trim_y_r <= AZT_TRIM_RESET;
		end else if (trim_y_we) begin
			trim_y_r <= reg_req.wdata;
		end
	end

	// Z trim, stored the same way.
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			trim_z_r <= AZT_TRIM_RESET;
		end else if (trim_z_we) begin
			trim_z_r <= reg_req.wdata;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Correction datapath, one adder per axis.

	azt_axis_adder #(.SAMPLE_W(SAMPLE_W)) u_add_x (
		.trim(trim_x_r),
		.fs_range(fs_range),
		.raw(sample_raw.x),
		.sum(sum_nxt.x)
	);

	azt_axis_adder #(.SAMPLE_W(SAMPLE_W)) u_add_y (
		.trim(trim_y_r),
		.fs_range(fs_range),
		.raw(sample_raw.y),
		.sum(sum_nxt.y)
	);

	azt_axis_adder #(.SAMPLE_W(SAMPLE_W)) u_add_z (
		.trim(trim_z_r),
		.fs_range(fs_range),
		.raw(sample_raw.z),
		.sum(sum_nxt.z)
	);

	// Corrected sample is captured once per acquisition; the output registers hold it until the next.
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			sample_out_r <= '0;
		end else if (sample_valid) begin
			sample_out_r <= sum_nxt;
		end
	end

	// The valid strobe follows the acquisition strobe by one cycle and lasts one cycle.
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			sample_out_valid_r <= 1'b0;
		end else begin
			sample_out_valid_r <= sample_valid;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Register read-back.

	assign wx = out_word(sample_out_r.x);
	assign wy = out_word(sample_out_r.y);
	assign wz = out_word(sample_out_r.z);

	// Read multiplexer; unmapped addresses read as zero but still answer, so the host never waits.
	always_comb begin
		unique case (reg_req.addr)
			AZT_ADDR_OUT_FIRST: reg_rdata_nxt = out_byte(wx, 1'b0);
			AZT_ADDR_OUT_X_LSB: reg_rdata_nxt = out_byte(wx, 1'b1);
			AZT_ADDR_OUT_Y_MSB: reg_rdata_nxt = out_byte(wy, 1'b0);
			AZT_ADDR_OUT_Y_LSB: reg_rdata_nxt = out_byte(wy, 1'b1);
			AZT_ADDR_OUT_Z_MSB: reg_rdata_nxt = out_byte(wz, 1'b0);
			AZT_ADDR_OUT_LAST: reg_rdata_nxt = out_byte(wz, 1'b1);
			AZT_ADDR_TRIM_X: reg_rdata_nxt = trim_x_r;
			AZT_ADDR_TRIM_Y: reg_rdata_nxt = trim_y_r;
			AZT_ADDR_TRIM_Z: reg_rdata_nxt = trim_z_r;
			default: reg_rdata_nxt = 8'h00;
		endcase
	end

	// Read data is registered one cycle after the request and held until the next read.
	// The bytes are not latched as a pair, so a sample landing between two byte reads mixes words.
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			reg_rdata_r <= 8'h00;
		end else if (reg_req.rd) begin
			reg_rdata_r <= reg_rdata_nxt;
		end
	end

	// The answer strobe is one pulse per read, unmapped addresses included.
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			reg_rvalid_r <= 1'b0;
		end else begin
			reg_rvalid_r <= reg_req.rd;
		end
	end

	assign reg_rdata = reg_rdata_r;
	assign reg_rvalid = reg_rvalid_r;
	assign sample_out = sample_out_r;
	assign sample_out_valid = sample_out_valid_r;

endmodule

// file: logic/azt_pkg.sv
/*
 * Package for the zero-g trim block: register addresses, reset values,
 * field widths, full-scale codes and the carrier structs of the block.
 * Assumes an 8-bit register address space and 14-bit acceleration samples.
 */
package azt_pkg;

	// Register addresses, byte-addressed as the serial register port presents them.
	localparam logic [7:0] AZT_ADDR_OUT_FIRST = 8'h01;
	localparam logic [7:0] AZT_ADDR_OUT_LAST = 8'h06;
	localparam logic [7:0] AZT_ADDR_OUT_X_LSB = 8'h02;
	localparam logic [7:0] AZT_ADDR_OUT_Y_MSB = 8'h03;
	localparam logic [7:0] AZT_ADDR_OUT_Y_LSB = 8'h04;
	localparam logic [7:0] AZT_ADDR_OUT_Z_MSB = 8'h05;
	localparam logic [7:0] AZT_ADDR_TRIM_X = 8'h2f;
	localparam logic [7:0] AZT_ADDR_TRIM_Y = 8'h30;
	localparam logic [7:0] AZT_ADDR_TRIM_Z = 8'h31;

	// Reset value of every trim register.
	localparam logic [7:0] AZT_TRIM_RESET = 8'h00;

	// Trim word width and weight of its least significant bit.
	localparam int AZT_TRIM_W = 8;
	localparam int AZT_TRIM_MG_PER_LSB = 2;

	// Output sample width and the low bits that pad the MSB/LSB byte pair.
	localparam int AZT_SAMPLE_W = 14;
	localparam int AZT_PAD_W = 2;

	// Full-scale range codes: 2 g, 4 g and 8 g.
	localparam logic [1:0] AZT_FS_2G = 2'h0;
	localparam logic [1:0] AZT_FS_4G = 2'h1;
	localparam logic [1:0] AZT_FS_8G = 2'h2;

	// Sample resolution in the 2 g range: 0.25 mg per count, so one trim step is 8 counts.
	localparam int AZT_TRIM_SHIFT_2G = 3;

	// One register access from the serial register port.
	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} azt_reg_req_t;

	// One raw or corrected three-axis sample.
	typedef struct packed {
		logic signed [AZT_SAMPLE_W-1:0] x;
		logic signed [AZT_SAMPLE_W-1:0] y;
		logic signed [AZT_SAMPLE_W-1:0] z;
	} azt_vec_t;

endpackage

// file: logic/azt_axis_adder.sv
/*
 * One axis of the correction datapath: scales a signed trim word to the
 * sample resolution of the selected range and adds it with saturation.
 * Assumes the range code is held steady while a sample is in flight.
 */
`timescale 1ns/100ps
module azt_axis_adder
	import azt_pkg::*;
#(
	parameter int SAMPLE_W = AZT_SAMPLE_W
) (
	input wire logic signed [AZT_TRIM_W-1:0] trim,
	input wire logic [1:0] fs_range,
	input wire logic signed [SAMPLE_W-1:0] raw,
	output logic signed [SAMPLE_W-1:0] sum
);

	localparam int EXT_W = SAMPLE_W + 2;
	localparam logic signed [EXT_W-1:0] SAT_MAX = EXT_W'((1 <<< (SAMPLE_W - 1)) - 1);
	localparam logic signed [EXT_W-1:0] SAT_MIN = -EXT_W'(1 <<< (SAMPLE_W - 1));

	// The finest range moves the trim up three bits; a narrower word would lose its sign.
	if (SAMPLE_W < AZT_TRIM_W + AZT_TRIM_SHIFT_2G + 1) begin : g_bad_width
		$error("azt_axis_adder: sample width too narrow for the scaled trim");
	end

	logic signed [EXT_W-1:0] trim_ext;
	logic signed [EXT_W-1:0] trim_scaled;
	logic signed [EXT_W-1:0] total;

	// Rescale the 2 mg step to the counts of the range; 8 g gives two counts per step.
	always_comb begin
		trim_ext = EXT_W'(trim);
		unique case (fs_range)
			AZT_FS_2G: trim_scaled = trim_ext <<< AZT_TRIM_SHIFT_2G;
			AZT_FS_4G: trim_scaled = trim_ext <<< (AZT_TRIM_SHIFT_2G - 1);
			default: trim_scaled = trim_ext <<< (AZT_TRIM_SHIFT_2G - 2);
		endcase
	end

	// Saturate rather than wrap, so a large trim never flips the sign of a near-full-scale sample.
	always_comb begin
		total = EXT_W'(raw) + trim_scaled;
		if (total > SAT_MAX)
			sum = SAMPLE_W'(SAT_MAX);
		else if (total < SAT_MIN)
			sum = SAMPLE_W'(SAT_MIN);
		else
			sum = SAMPLE_W'(total);
	end

endmodule

// file: tb/azt_checker.sv
/* Assertions on the zero-g trim block.
   Assumes binding to azt_zero_g_trim. */
`timescale 1ns/100ps
module azt_checker
	import azt_pkg::*;
#(
	parameter int SAMPLE_W = AZT_SAMPLE_W
) (
	input wire logic clk_sys,
	input wire logic rst,
	input wire azt_reg_req_t reg_req,
	input wire logic [7:0] reg_rdata,
	input wire logic reg_rvalid,
	input wire logic active_mode,
	input wire logic [1:0] fs_range,
	input wire logic sample_valid,
	input wire azt_vec_t sample_raw,
	input wire azt_vec_t sample_out,
	input wire logic sample_out_valid
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);
	logic [7:0] tx_r;
	int ex;
	// Own copy of the X trim, so the sum is predicted apart from the design.
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst)
			tx_r <= 8'h00;
		else if (reg_req.wr && !active_mode && reg_req.addr == AZT_ADDR_TRIM_X)
			tx_r <= reg_req.wdata;
	end
	// Expected X sum; it clamps because a wrap would flip the sign.
	always_comb begin
		ex = int'($signed(sample_raw.x)) + (int'($signed(tx_r)) <<< (fs_range == AZT_FS_2G ? 3 : fs_range == AZT_FS_4G ? 2 : 1));
		if (ex > 8191)
			ex = 8191;
		if (ex < -8192)
			ex = -8192;
	end
	a_read_answer: assert property (reg_req.rd |=> reg_rvalid) else $error("no read answer");
	a_sample_lag: assert property (sample_valid |=> sample_out_valid) else $error("no sample");
	a_trim_sum: assert property (sample_valid |=> sample_out.x == $past(ex)) else $error("bad X sum");
	a_out_byte: assert property (reg_req.rd && reg_req.addr == AZT_ADDR_OUT_FIRST |=>
		reg_rdata == $past(sample_out.x[13:6])) else $error("bad X byte");
	a_standby_write: assert property (reg_req.wr && !active_mode && reg_req.addr == AZT_ADDR_TRIM_X ##2
		reg_req.rd && reg_req.addr == AZT_ADDR_TRIM_X |=> reg_rdata == $past(reg_req.wdata, 3)) else $error("lost");
	a_active_drop: assert property (reg_req.rd && reg_req.addr == AZT_ADDR_TRIM_X ##2 reg_req.wr && active_mode
		##2 reg_req.rd && reg_req.addr == AZT_ADDR_TRIM_X |=> reg_rdata == $past(reg_rdata, 4)) else $error("taken");
	a_answer_pulse: assert property (!reg_req.rd |=> !reg_rvalid) else $error("stray read answer");
	a_sample_pulse: assert property (!sample_valid |=> !sample_out_valid) else $error("stray sample");
	cover property (sample_valid && fs_range == AZT_FS_8G);
	cover property (sample_valid && fs_range == 2'h3);
	cover property (reg_req.wr && active_mode);
	cover property (reg_req.rd && reg_req.addr == AZT_ADDR_OUT_FIRST);
endmodule
bind azt_zero_g_trim azt_checker #(.SAMPLE_W(SAMPLE_W)) u_chk (.clk_sys(clk_sys), .rst(rst), .reg_req(reg_req),
	.reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .active_mode(active_mode), .fs_range(fs_range),
	.sample_valid(sample_valid), .sample_raw(sample_raw), .sample_out(sample_out), .sample_out_valid(sample_out_valid));

// file: tb/azt_host.sv
/* Host model on the register port.
   Assumes one caller at a time. */
`timescale 1ns/100ps
module azt_host
	import azt_pkg::*;
(
	input wire logic clk_sys,
	output azt_reg_req_t reg_req,
	input wire logic [7:0] reg_rdata,
	input wire logic reg_rvalid
);
	initial reg_req = '{wr: 1'b0, rd: 1'b0, addr: 8'hff, wdata: 8'hff};
	// One access; when idle the lines show inverted values, so stale data is never read as live.
	task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q, output logic ok);
		@(negedge clk_sys);
		reg_req = '{wr: w, rd: !w, addr: a, wdata: d};
		@(negedge clk_sys);
		reg_req = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
		q = reg_rdata;
		ok = w || reg_rvalid === 1'b1;
	endtask
endmodule

// file: tb/azt_zero_g_trim_test.sv
/* Testbench of the zero-g trim block.
   Assumes the host model owns the register port. */
`timescale 1ns/100ps
module azt_zero_g_trim_test
	import azt_pkg::*;
;
	logic clk_sys = 1'b0, rst = 1'b1, active_mode = 1'b0, sample_valid = 1'b0, ok, reg_rvalid, sample_out_valid;
	logic [1:0] fs_range = AZT_FS_2G;
	logic [7:0] reg_rdata, q;
	azt_reg_req_t reg_req;
	azt_vec_t sample_raw = '0, sample_out, e;
	int err_total = 0, num_checks = 0;
	`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin $display("[ERR] %0t got %h", $time, a); err_total++; end end
	always #10 clk_sys = ~clk_sys;
	azt_host u_host (.clk_sys(clk_sys), .reg_req(reg_req), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));
	azt_zero_g_trim DUT (.clk_sys(clk_sys), .rst(rst), .reg_req(reg_req), .reg_rdata(reg_rdata),
		.reg_rvalid(reg_rvalid), .active_mode(active_mode), .fs_range(fs_range), .sample_valid(sample_valid),
		.sample_raw(sample_raw), .sample_out(sample_out), .sample_out_valid(sample_out_valid));
	// Register accesses through the host model.
	task automatic rd(input logic [7:0] a, input logic [7:0] x);
		u_host.acc(1'b0, a, 8'h00, q, ok);
		`CHK(ok, 1'b1)
		`CHK(q, x)
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		u_host.acc(1'b1, a, d, q, ok);
	endtask
	// One sample in, its sum checked one cycle later.
	task automatic smp(input logic [1:0] f, input azt_vec_t r, input azt_vec_t x);
		@(negedge clk_sys);
		fs_range = f;
		sample_raw = r;
		sample_valid = 1'b1;
		@(negedge clk_sys);
		sample_valid = 1'b0;
		`CHK(sample_out_valid, 1'b1)
		`CHK(sample_out, x)
	endtask
	task automatic stop_test();
		$display("checks %0d errors %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	// A hang counts as a mismatch.
	initial begin
		repeat (3000) @(posedge clk_sys);
		err_total++;
		stop_test();
	end
	initial begin
		repeat (6) @(posedge clk_sys);
		@(negedge clk_sys);
		rst = 1'b0;
		rd(AZT_ADDR_TRIM_X, AZT_TRIM_RESET);
		rd(AZT_ADDR_TRIM_Z, AZT_TRIM_RESET);
		wr(AZT_ADDR_TRIM_Y, 8'h80);
		wr(AZT_ADDR_TRIM_Z, 8'h7f);
		rd(AZT_ADDR_TRIM_Y, 8'h80);
		rd(AZT_ADDR_TRIM_Z, 8'h7f);
		wr(AZT_ADDR_TRIM_X, 8'(-60 / AZT_TRIM_MG_PER_LSB));
		rd(AZT_ADDR_TRIM_X, 8'he2);
		active_mode = 1'b1;
		wr(AZT_ADDR_TRIM_X, 8'h55);
		rd(AZT_ADDR_TRIM_X, 8'he2);
		rd(8'h00, 8'h00);
		$display("test registers done");
		// Code 3 is served as 8 g, so it scales like code 2.
		for (int f = 0; f < 4; f++) begin
			e = '{x: 14'(100 - (30 << (f > 2 ? 1 : 3 - f))), y: 14'h2000, z: 14'h1fff};
			smp(2'(f), '{x: 14'd100, y: 14'h20c0, z: 14'h1fff}, e);
			rd(AZT_ADDR_OUT_FIRST, e.x[13:6]);
			rd(AZT_ADDR_OUT_X_LSB, {e.x[5:0], 2'b00});
			rd(AZT_ADDR_OUT_Y_MSB, e.y[13:6]);
			rd(AZT_ADDR_OUT_LAST, {e.z[5:0], 2'b00});
		end
		$display("test samples done");
		stop_test();
	end
endmodule
